// ---- verilog/irc_defines.svh ----
// Register offsets, field positions, reset values and source indices of the interrupt routing block.
// Assumes nothing; holds definitions only.
`ifndef IRC_DEFINES_SVH
`define IRC_DEFINES_SVH

`define IRC_ADDR_CFG4 8'h0d
`define IRC_ADDR_CFG5 8'h0e
`define IRC_ADDR_LOFF 8'h0f

`define IRC_CFG4_RST 8'h00
`define IRC_CFG5_RST 8'h71
`define IRC_LOFF_RST 8'h00
// Bits 4 and 2 of the fourth register are kept at zero.
`define IRC_CFG4_WMASK 8'heb

`define IRC_B_RANGE_EN 7
`define IRC_F_THR_HI 6
`define IRC_F_THR_LO 5
`define IRC_B_MISS_EN 3
`define IRC_B_LEG_SW 1
`define IRC_B_AMP_SW 0
`define IRC_B_OSC_EN 7
`define IRC_F_ROUTE_HI 6
`define IRC_F_ROUTE_LO 4
`define IRC_B_BADCMD_EN 3
`define IRC_B_LOFF_EN 7

`define IRC_THR_24BIT 2'h0
`define IRC_DATA_BITS 24
`define IRC_NSRC 5
`define IRC_SRC_LOFF 0
`define IRC_SRC_RANGE 1
`define IRC_SRC_BUF 2
`define IRC_SRC_MISS 3
`define IRC_SRC_BADCMD 4

`endif

// ---- verilog/irc_pkg.sv ----
// Types shared by the interrupt routing block.
// Assumes irc_defines.svh is on the include path.
`include "irc_defines.svh"

package irc_pkg;

	typedef enum logic [2:0] {
		IRC_ROUTE_ALL_ONE = 3'b000,
		IRC_ROUTE_ALL_TWO = 3'b001,
		IRC_ROUTE_MISS_TWO = 3'b010,
		IRC_ROUTE_BUF_TWO = 3'b011,
		IRC_ROUTE_RANGE_TWO = 3'b100,
		IRC_ROUTE_LOFF_TWO = 3'b101,
		IRC_ROUTE_BADCMD_TWO = 3'b110,
		IRC_ROUTE_NONE = 3'b111
	} irc_route_e;

	typedef struct packed {
		logic one;
		logic one_oe;
		logic two;
		logic two_oe;
	} irc_pins_s;

	typedef struct packed {
		logic [7:0] cfg4;
		logic [7:0] cfg5;
		logic [7:0] loff;
		logic [`IRC_NSRC-1:0] pend;
		logic [7:0] rdata;
		irc_pins_s pins;
		logic leg_sw;
		logic amp_sw;
		logic osc_en;
	} irc_state_s;

endpackage

// ---- verilog/irc_sync.sv ----
// Two-stage synchroniser for levels arriving from outside the clock domain.
// Assumes an active-low reset already released in step with the clock.
`timescale 1ns/1ps

module irc_sync
	import irc_pkg::*;
#(
	parameter int WIDTH = 1
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_n,
	// Level in and synchronised level out.
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);

	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] stable;
	} irc_sync_s;

	irc_sync_s st_reg;
	irc_sync_s st_next;

	// The first stage feeds only the second stage.
	always_comb begin
		st_next.meta = d;
		st_next.stable = st_reg.meta;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign q = st_reg.stable;

endmodule // irc_sync

// ---- verilog/irc_route.sv ----
// Steers the five pending interrupt sources onto the two general pins.
// Assumes pending flags and routing code from the same clock; purely combinational.
`timescale 1ns/1ps
`include "irc_defines.svh"

module irc_route
	import irc_pkg::*;
(
	// Routing code and pending sources.
	input wire logic [2:0] code,
	input wire logic [`IRC_NSRC-1:0] pend,
	// Pin levels and enables.
	output irc_pins_s pins
);

	logic [`IRC_NSRC-1:0] to_two;
	logic [`IRC_NSRC-1:0] to_one;
	logic none;

	assign none = (code == IRC_ROUTE_NONE); // R14

	genvar i;
	generate
		for (i = 0; i < `IRC_NSRC; i++) begin : g_src
			// R8
			assign to_two[i] = (code == IRC_ROUTE_ALL_TWO) // R10
				|| (code == IRC_ROUTE_MISS_TWO && i == `IRC_SRC_MISS) // R11
				|| (code == IRC_ROUTE_BUF_TWO && i == `IRC_SRC_BUF) // R12
				|| (code == IRC_ROUTE_RANGE_TWO && i == `IRC_SRC_RANGE) // R13
				|| (code == IRC_ROUTE_LOFF_TWO && i == `IRC_SRC_LOFF) // R17
				|| (code == IRC_ROUTE_BADCMD_TWO && i == `IRC_SRC_BADCMD); // R17
			assign to_one[i] = !none && !to_two[i]; // R9
		end
	endgenerate

	always_comb begin
		pins.one = |(pend & to_one);
		pins.one_oe = |to_one;
		pins.two = |(pend & to_two);
		pins.two_oe = |to_two;
	end

endmodule // irc_route

// ---- verilog/irc_top.sv ----
// Interrupt enables, out-of-range detection and routing of five interrupt sources to two pins.
// Assumes register writes, events and conversion results come from logic on CLK_SYS;
// only the clock-select pin and RESET_N arrive from outside; the pin is synchronised here and RESET_N on its release.
//
// How it works
// (R1) Out-of-range interrupt raised only while its enable, fourth register bit 7, is set.
// (R2) Threshold code 00 flags results beyond the 24-bit range; other codes flag nothing.
// (R3) Clock-missing interrupt raised only while fourth register bit 3 is set.
// (R4) Fourth register bit 1 closes the driven-leg input to amplifier positive switch.
// (R5) Fourth register bit 0 closes the amplifier output to negative input switch.
// (R6) Fifth register bit 7 enables the clock-watch oscillator; default off.
// (R7) The oscillator serves only while the clock-select pin chooses the external clock.
// (R8) Routing field bits 6:4 steers lead-off, range, buffer, clock-miss, bad-command sources.
// (R9) Code 000 sends all five sources to pin one.
// (R10) Code 001 sends all five sources to pin two.
// (R11) Code 010 sends clock-missing to pin two, the rest to pin one.
// (R12) Code 011 sends buffer to pin two, the rest to pin one.
// (R13) Code 100 sends out-of-range to pin two, the rest to pin one.
// (R14) Code 111, the reset value, drives neither pin.
// (R15) Bad-command interrupt raised only while fifth register bit 3 is set.
// (R16) Lead-off interrupt raised only while lead-off step register bit 7 is set.
// (R17) Code 101 sends lead-off to pin two; 110 sends bad-command to pin two.
// (R18) Host writes zero to reserved bits and uses no reserved threshold codes.
`timescale 1ns/1ps
`include "irc_defines.svh"

module irc_top
	import irc_pkg::*;
#(
	parameter int RES_W = 32
) (
	// Clock and reset.
	input wire logic CLK_SYS,
	input wire logic RESET_N,
	// Register access from the serial command decoder.
	input wire logic REG_WR,
	input wire logic [7:0] REG_ADDR,
	input wire logic [7:0] REG_WDATA,
	output logic [7:0] REG_RDATA,
	// Conversion results.
	input wire logic CONV_VALID,
	input wire logic [RES_W-1:0] CONV_RESULT,
	// Interrupt events and their clears.
	input wire logic LEAD_OFF_EVT,
	input wire logic BUF_EVT,
	input wire logic CLK_MISS_EVT,
	input wire logic BAD_CMD_EVT,
	input wire logic [`IRC_NSRC-1:0] IRQ_CLR,
	output logic [`IRC_NSRC-1:0] IRQ_PENDING,
	// Clock-select pin.
	input wire logic CLOCK_SOURCE_SELECT_PIN,
	// General pins.
	output logic GENERAL_PIN_ONE_O,
	output logic GENERAL_PIN_ONE_OE,
	output logic GENERAL_PIN_TWO_O,
	output logic GENERAL_PIN_TWO_OE,
	// Analog switch and oscillator controls.
	output logic LEG_IN_TO_AMP_POS_SWITCH,
	output logic AMP_OUT_TO_AMP_NEG_SWITCH,
	output logic CLOCK_WATCH_OSC_ENABLE
);

	logic [1:0] rst_sync_reg;
	logic rst_n;
	logic clock_source_select_pin_q;
	logic range_out;
	logic [`IRC_NSRC-1:0] set_evt;
	irc_pins_s pins_next;
	irc_state_s st_reg;
	irc_state_s st_next;

	// Reset asserts at once and releases two edges later.
	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			rst_sync_reg <= 2'h0;
		end else begin
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_reg[1];

	irc_sync #(
		.WIDTH(1)
	) u_clock_source_select_pin_sync (
		.clk(CLK_SYS),
		.rst_n(rst_n),
		.d(CLOCK_SOURCE_SELECT_PIN),
		.q(clock_source_select_pin_q)
	);

	// A result fits in 24 bits only when every bit above the sign matches it.
	assign range_out = !((&CONV_RESULT[RES_W-1:`IRC_DATA_BITS-1])
		|| !(|CONV_RESULT[RES_W-1:`IRC_DATA_BITS-1]));

	always_comb begin
		set_evt = '0;
		set_evt[`IRC_SRC_LOFF] = LEAD_OFF_EVT && st_reg.loff[`IRC_B_LOFF_EN]; // R16
		set_evt[`IRC_SRC_RANGE] = CONV_VALID && range_out
			&& st_reg.cfg4[`IRC_B_RANGE_EN] // R1
			&& (st_reg.cfg4[`IRC_F_THR_HI:`IRC_F_THR_LO] == `IRC_THR_24BIT); // R2
		set_evt[`IRC_SRC_BUF] = BUF_EVT;
		// The watch only exists on the external clock, so a miss needs it running.
		set_evt[`IRC_SRC_MISS] = CLK_MISS_EVT && st_reg.cfg4[`IRC_B_MISS_EN] // R3
			&& st_reg.cfg5[`IRC_B_OSC_EN] && !clock_source_select_pin_q; // R7
		set_evt[`IRC_SRC_BADCMD] = BAD_CMD_EVT && st_reg.cfg5[`IRC_B_BADCMD_EN]; // R15
	end

	irc_route u_route (
		.code(st_next.cfg5[`IRC_F_ROUTE_HI:`IRC_F_ROUTE_LO]), // R8
		.pend(st_next.pend),
		.pins(pins_next)
	);

	always_comb begin
		st_next = st_reg;
		if (REG_WR) begin
			unique case (REG_ADDR)
				`IRC_ADDR_CFG4: begin
					st_next.cfg4 = REG_WDATA & `IRC_CFG4_WMASK; // R18
				end
				`IRC_ADDR_CFG5: begin
					st_next.cfg5 = REG_WDATA;
				end
				`IRC_ADDR_LOFF: begin
					st_next.loff = REG_WDATA;
				end
				default: begin
				end
			endcase
		end
		// A set in the same cycle as its clear wins, so no event is lost.
		st_next.pend = (st_reg.pend & ~IRQ_CLR) | set_evt;
		unique case (REG_ADDR)
			`IRC_ADDR_CFG4: st_next.rdata = st_reg.cfg4;
			`IRC_ADDR_CFG5: st_next.rdata = st_reg.cfg5;
			`IRC_ADDR_LOFF: st_next.rdata = st_reg.loff;
			default: st_next.rdata = 8'h00;
		endcase
		st_next.pins = pins_next;
		st_next.leg_sw = st_next.cfg4[`IRC_B_LEG_SW]; // R4
		st_next.amp_sw = st_next.cfg4[`IRC_B_AMP_SW]; // R5
		st_next.osc_en = st_next.cfg5[`IRC_B_OSC_EN] && !clock_source_select_pin_q; // R6 R7
	end

	always_ff @(posedge CLK_SYS or negedge rst_n) begin
		if (!rst_n) begin
			st_reg.cfg4 <= `IRC_CFG4_RST;
			st_reg.cfg5 <= `IRC_CFG5_RST;
			st_reg.loff <= `IRC_LOFF_RST;
			st_reg.pend <= '0;
			st_reg.rdata <= 8'h00;
			st_reg.pins <= '0;
			st_reg.leg_sw <= 1'b0;
			st_reg.amp_sw <= 1'b0;
			st_reg.osc_en <= 1'b0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign REG_RDATA = st_reg.rdata;
	assign IRQ_PENDING = st_reg.pend;
	assign GENERAL_PIN_ONE_O = st_reg.pins.one;
	assign GENERAL_PIN_ONE_OE = st_reg.pins.one_oe;
	assign GENERAL_PIN_TWO_O = st_reg.pins.two;
	assign GENERAL_PIN_TWO_OE = st_reg.pins.two_oe;
	assign LEG_IN_TO_AMP_POS_SWITCH = st_reg.leg_sw;
	assign AMP_OUT_TO_AMP_NEG_SWITCH = st_reg.amp_sw;
	assign CLOCK_WATCH_OSC_ENABLE = st_reg.osc_en;

	property p_range_gate;
		@(posedge CLK_SYS) disable iff (!rst_n)
		!st_reg.cfg4[`IRC_B_RANGE_EN] && !st_reg.pend[`IRC_SRC_RANGE]
			|=> !st_reg.pend[`IRC_SRC_RANGE];
	endproperty
	a_range_gate: assert property (p_range_gate) else $error("range flag set while off"); // R1

	property p_range_set;
		@(posedge CLK_SYS) disable iff (!rst_n)
		st_reg.cfg4[7:5] == 3'b100 && CONV_VALID && range_out
			|=> st_reg.pend[`IRC_SRC_RANGE] && IRQ_PENDING[`IRC_SRC_RANGE];
	endproperty
	a_range_set: assert property (p_range_set) else $error("range flag not set"); // R2

	property p_miss_gate;
		@(posedge CLK_SYS) disable iff (!rst_n)
		!st_reg.cfg4[`IRC_B_MISS_EN] && !st_reg.pend[`IRC_SRC_MISS]
			|=> !st_reg.pend[`IRC_SRC_MISS];
	endproperty
	a_miss_gate: assert property (p_miss_gate) else $error("miss flag set while off"); // R3

	property p_leg_sw;
		@(posedge CLK_SYS) disable iff (!rst_n)
		REG_WR && REG_ADDR == `IRC_ADDR_CFG4 |=> LEG_IN_TO_AMP_POS_SWITCH == $past(REG_WDATA[1]);
	endproperty
	a_leg_sw: assert property (p_leg_sw) else $error("leg switch wrong"); // R4

	property p_amp_sw;
		@(posedge CLK_SYS) disable iff (!rst_n)
		REG_WR && REG_ADDR == `IRC_ADDR_CFG4 |=> AMP_OUT_TO_AMP_NEG_SWITCH == $past(REG_WDATA[0]);
	endproperty
	a_amp_sw: assert property (p_amp_sw) else $error("amp switch wrong"); // R5

	property p_osc;
		@(posedge CLK_SYS) disable iff (!rst_n)
		CLOCK_WATCH_OSC_ENABLE |-> st_reg.cfg5[`IRC_B_OSC_EN] && !$past(clock_source_select_pin_q);
	endproperty
	a_osc: assert property (p_osc) else $error("oscillator on without cause"); // R6

	property p_all_one;
		@(posedge CLK_SYS) disable iff (!rst_n)
		st_reg.cfg5[6:4] == 3'b000 |-> GENERAL_PIN_ONE_O == (|st_reg.pend) && !GENERAL_PIN_TWO_OE;
	endproperty
	a_all_one: assert property (p_all_one) else $error("code 000 misrouted"); // R9

	property p_all_two;
		@(posedge CLK_SYS) disable iff (!rst_n)
		st_reg.cfg5[6:4] == 3'b001 |-> GENERAL_PIN_TWO_O == (|st_reg.pend) && !GENERAL_PIN_ONE_OE;
	endproperty
	a_all_two: assert property (p_all_two) else $error("code 001 misrouted"); // R10

	property p_miss_two;
		@(posedge CLK_SYS) disable iff (!rst_n)
		st_reg.cfg5[6:4] == 3'b010 |-> GENERAL_PIN_TWO_O == st_reg.pend[3]
			&& GENERAL_PIN_ONE_O == (|{st_reg.pend[4], st_reg.pend[2:0]});
	endproperty
	a_miss_two: assert property (p_miss_two) else $error("code 010 misrouted"); // R11

	property p_none;
		@(posedge CLK_SYS) disable iff (!rst_n)
		st_reg.cfg5[6:4] == 3'b111 |-> !GENERAL_PIN_ONE_OE && !GENERAL_PIN_TWO_OE;
	endproperty
	a_none: assert property (p_none) else $error("code 111 drives a pin"); // R14

	property p_badcmd;
		@(posedge CLK_SYS) disable iff (!rst_n)
		BAD_CMD_EVT && st_reg.cfg5[3] |=> IRQ_PENDING[`IRC_SRC_BADCMD];
	endproperty
	a_badcmd: assert property (p_badcmd) else $error("bad command not flagged"); // R15

	property p_loff_gate;
		@(posedge CLK_SYS) disable iff (!rst_n)
		!st_reg.loff[7] && !st_reg.pend[0] |=> !IRQ_PENDING[`IRC_SRC_LOFF];
	endproperty
	a_loff_gate: assert property (p_loff_gate) else $error("lead-off flag set while off"); // R16

	property p_buf_two;
		@(posedge CLK_SYS) disable iff (!rst_n)
		st_reg.cfg5[6:4] == 3'b011 |-> GENERAL_PIN_TWO_O == st_reg.pend[2]
			&& GENERAL_PIN_ONE_O == (|{st_reg.pend[4:3], st_reg.pend[1:0]});
	endproperty
	a_buf_two: assert property (p_buf_two) else $error("code 011 misrouted"); // R12

	property p_range_two;
		@(posedge CLK_SYS) disable iff (!rst_n)
		st_reg.cfg5[6:4] == 3'b100 |-> GENERAL_PIN_TWO_O == st_reg.pend[1]
			&& GENERAL_PIN_ONE_O == (|{st_reg.pend[4:2], st_reg.pend[0]});
	endproperty
	a_range_two: assert property (p_range_two) else $error("code 100 misrouted"); // R13

	property p_loff_two;
		@(posedge CLK_SYS) disable iff (!rst_n)
		st_reg.cfg5[6:4] == 3'b101 |-> GENERAL_PIN_TWO_O == st_reg.pend[0]
			&& GENERAL_PIN_ONE_O == (|st_reg.pend[4:1]);
	endproperty
	a_loff_two: assert property (p_loff_two) else $error("code 101 misrouted"); // R17

	property p_badcmd_two;
		@(posedge CLK_SYS) disable iff (!rst_n)
		st_reg.cfg5[6:4] == 3'b110 |-> GENERAL_PIN_TWO_O == st_reg.pend[4]
			&& GENERAL_PIN_ONE_O == (|st_reg.pend[3:0]);
	endproperty
	a_badcmd_two: assert property (p_badcmd_two) else $error("code 110 misrouted"); // R17

	property p_pin_driven;
		@(posedge CLK_SYS) disable iff (!rst_n)
		st_reg.cfg5[6:4] != 3'b111 |-> GENERAL_PIN_ONE_OE || GENERAL_PIN_TWO_OE;
	endproperty
	a_pin_driven: assert property (p_pin_driven) else $error("routed code drives no pin"); // R8

	property p_buf_set;
		@(posedge CLK_SYS) disable iff (!rst_n)
		BUF_EVT |=> IRQ_PENDING[`IRC_SRC_BUF];
	endproperty
	a_buf_set: assert property (p_buf_set) else $error("buffer event not flagged"); // R8

	property p_miss_ext;
		@(posedge CLK_SYS) disable iff (!rst_n)
		clock_source_select_pin_q && !st_reg.pend[`IRC_SRC_MISS] |=> !st_reg.pend[`IRC_SRC_MISS];
	endproperty
	a_miss_ext: assert property (p_miss_ext) else $error("miss flag set on own clock"); // R7

	property p_badcmd_gate;
		@(posedge CLK_SYS) disable iff (!rst_n)
		!st_reg.cfg5[`IRC_B_BADCMD_EN] && !st_reg.pend[`IRC_SRC_BADCMD]
			|=> !st_reg.pend[`IRC_SRC_BADCMD];
	endproperty
	a_badcmd_gate: assert property (p_badcmd_gate) else $error("bad command flag set while off"); // R15

	property p_loff_set;
		@(posedge CLK_SYS) disable iff (!rst_n)
		LEAD_OFF_EVT && st_reg.loff[`IRC_B_LOFF_EN] |=> IRQ_PENDING[`IRC_SRC_LOFF];
	endproperty
	a_loff_set: assert property (p_loff_set) else $error("lead-off event not flagged"); // R16

endmodule // irc_top

// ---- dv/irc_host_model.sv ----
// Host-side model of the two general pins and of the clock-select pin.
// Assumes the pin enables are high while the device drives a pin.
`timescale 1ns/1ps

module irc_host_model (
	// Clock.
	input wire logic clk,
	// Device pin drivers.
	input wire logic one_o,
	input wire logic one_oe,
	input wire logic two_o,
	input wire logic two_oe,
	// Clock choice and wire levels.
	input wire logic use_ext_clk,
	output logic pin_one,
	output logic pin_two,
	output logic clk_sel_pin
);
	logic float_one = 1'b0;
	logic float_two = 1'b0;

	// The pins have no pull, so an undriven pin wanders and a stale level is never trusted.
	always @(posedge clk) begin
		float_one <= ~pin_one;
		float_two <= ~pin_two;
	end

	assign pin_one = one_oe ? one_o : float_one;
	assign pin_two = two_oe ? two_o : float_two;
	assign clk_sel_pin = ~use_ext_clk;
endmodule // irc_host_model

// ---- dv/irc_top_tb.sv ----
// Self-checking bench for the interrupt routing block.
// Assumes a host that drives the clock-select pin and watches the two general pins.
`timescale 1ns/1ps
`include "irc_defines.svh"

module irc_top_tb;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic wr = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic [7:0] rdata;
	logic cv = 1'b0;
	logic [31:0] cres = 32'h0;
	logic lo = 1'b0;
	logic bf = 1'b0;
	logic cm = 1'b0;
	logic bc = 1'b0;
	logic [4:0] clr = 5'h00;
	logic [4:0] pend;
	logic o1, oe1, o2, oe2, p1, p2, sel, leg, amp, osc;
	logic use_ext = 1'b0;
	logic [4:0] two;
	logic [4:0] one;
	int num_errors = 0;
	int checked = 0;

	always #12.5 clk = ~clk;

	irc_top irc_top_inst (.CLK_SYS(clk), .RESET_N(rst_n), .REG_WR(wr), .REG_ADDR(addr),
		.REG_WDATA(wdata), .REG_RDATA(rdata), .CONV_VALID(cv), .CONV_RESULT(cres),
		.LEAD_OFF_EVT(lo), .BUF_EVT(bf), .CLK_MISS_EVT(cm), .BAD_CMD_EVT(bc), .IRQ_CLR(clr),
		.IRQ_PENDING(pend), .CLOCK_SOURCE_SELECT_PIN(sel), .GENERAL_PIN_ONE_O(o1),
		.GENERAL_PIN_ONE_OE(oe1), .GENERAL_PIN_TWO_O(o2), .GENERAL_PIN_TWO_OE(oe2),
		.LEG_IN_TO_AMP_POS_SWITCH(leg), .AMP_OUT_TO_AMP_NEG_SWITCH(amp),
		.CLOCK_WATCH_OSC_ENABLE(osc));

	irc_host_model irc_host_model_inst (.clk(clk), .one_o(o1), .one_oe(oe1), .two_o(o2),
		.two_oe(oe2), .use_ext_clk(use_ext), .pin_one(p1), .pin_two(p2), .clk_sel_pin(sel));

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		wr = 1'b1;
		addr = a;
		wdata = d;
		@(negedge clk);
		wr = 1'b0;
	endtask

	task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
		@(negedge clk);
		addr = a;
		@(negedge clk);
		check(rdata, exp);
	endtask

	// One event pulse per call; source order as in the pending flags.
	task automatic fire(input int s, input logic [31:0] res);
		@(negedge clk);
		{bc, cm, bf, cv, lo} = 5'(5'h01 << s);
		cres = res;
		@(negedge clk);
		{bc, cm, bf, cv, lo} = 5'h00;
	endtask

	task automatic clear_all();
		@(negedge clk);
		clr = 5'h1f;
		@(negedge clk);
		clr = 5'h00;
	endtask

	// Sources that each routing code sends to pin two.
	function automatic logic [4:0] route_two(input logic [2:0] c);
		case (c)
			3'h1: return 5'h1f;
			3'h2: return 5'h08;
			3'h3: return 5'h04;
			3'h4: return 5'h02;
			3'h5: return 5'h01;
			3'h6: return 5'h10;
			default: return 5'h00;
		endcase
	endfunction

	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge clk);
		num_errors++;
		tally_and_finish();
	end

	initial begin
		repeat (16) @(negedge clk);
		rst_n = 1'b1;
		repeat (3) @(negedge clk);
		check({6'h0, oe1, oe2}, 8'h00);
		rd_reg(`IRC_ADDR_CFG4, 8'h00);
		rd_reg(`IRC_ADDR_CFG5, 8'h71);
		rd_reg(`IRC_ADDR_LOFF, 8'h00);
		wr_reg(8'h20, 8'hff);
		rd_reg(8'h20, 8'h00);
		wr_reg(`IRC_ADDR_CFG4, 8'h8b);
		rd_reg(`IRC_ADDR_CFG4, 8'h8b);
		check({6'h0, leg, amp}, 8'h03);
		wr_reg(`IRC_ADDR_CFG4, 8'h02);
		check({6'h0, leg, amp}, 8'h02);
		// The oscillator must follow the pin only once the pin has crossed the synchroniser.
		use_ext = 1'b1;
		wr_reg(`IRC_ADDR_CFG5, 8'h80);
		repeat (4) @(negedge clk);
		check({7'h0, osc}, 8'h01);
		use_ext = 1'b0;
		repeat (4) @(negedge clk);
		check({7'h0, osc}, 8'h00);
		// The external clock stays chosen from here on, so clock-miss events can be taken.
		use_ext = 1'b1;
		repeat (4) @(negedge clk);
		check({7'h0, osc}, 8'h01);
		wr_reg(`IRC_ADDR_CFG5, 8'h00);
		check({7'h0, osc}, 8'h00);
		for (int s = 0; s < 5; s++) begin
			fire(s, 32'h0080_0000);
		end
		check({3'h0, pend}, 8'h04);
		wr_reg(`IRC_ADDR_CFG4, 8'h80);
		fire(1, 32'h007f_ffff);
		fire(1, 32'hff80_0000);
		check({3'h0, pend}, 8'h04);
		fire(1, 32'hff7f_ffff);
		check({3'h0, pend}, 8'h06);
		clear_all();
		wr_reg(`IRC_ADDR_CFG4, 8'h88);
		wr_reg(`IRC_ADDR_LOFF, 8'h80);
		for (int c = 0; c < 8; c++) begin
			wr_reg(`IRC_ADDR_CFG5, {1'b1, 3'(c), 4'h8});
			two = route_two(3'(c));
			one = (c == 7) ? 5'h00 : ~two;
			for (int s = 0; s < 5; s++) begin
				fire(s, 32'h8000_0000);
				check({3'h0, pend}, 8'(5'h01 << s));
				check({4'h0, oe1, oe1 & p1, oe2, oe2 & p2},
					{4'h0, |one, one[s], |two, two[s]});
				clear_all();
				check({3'h0, pend}, 8'h00);
			end
		end
		tally_and_finish();
	end
endmodule // irc_top_tb
